/* ccs_pkg.sv */
/*
  Constants, command codes and carrier types for the core status and
  pointer block. Assumes a byte-wide register map reached through a
  32-bit bus slave.
*/
// What this block does
// - stack pointer increments before each stacked byte
// - two pointer bytes form one 16-bit pointer
// - selector bit picks main or alternate pointer
// - add/subtract carry from most significant bit
// - multiply and divide always clear carry
// - decimal adjust sets carry on decimal overflow
// - compare sets carry when first below second
// - half carry from low nibble carry/borrow
// - two bank bits pick one of four banks
// - add overflow: carries out of bit6/bit7 differ
// - subtract overflow: borrows out of bit6/bit7 differ
// - multiply overflow when product exceeds 255
// - divide by zero sets overflow, else cleared
// - parity bit tracks odd ones, read-only
// - carry instructions set, clear or compute carry
// - two user flags are plain storage
// - aux register is multiply/divide second operand
package ccs_pkg;
  ////////////////////////////////////////////////////////////////////
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_STACK = 8'h81;
  localparam logic [7:0] IDX_DPL = 8'h82;
  localparam logic [7:0] IDX_DPH = 8'h83;
  localparam logic [7:0] IDX_POWER = 8'h87;
  localparam logic [7:0] IDX_AUX1 = 8'ha2;
  localparam logic [7:0] IDX_STATUS = 8'hd0;
  localparam logic [7:0] IDX_ACC = 8'he0;
  localparam logic [7:0] IDX_AUXB = 8'hf0;
  localparam int ADDR_W = 10;
  ////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_STACK = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_POWER = 8'h10;
  // bit positions
  localparam int SW_CY = 7;
  localparam int SW_AC = 6;
  localparam int SW_F0 = 5;
  localparam int SW_RS1 = 4;
  localparam int SW_RS0 = 3;
  localparam int SW_OV = 2;
  localparam int SW_F1 = 1;
  localparam int SW_P = 0;
  localparam int AUX1_SEL = 0;
  localparam logic [7:0] POWER_RSV_MASK = 8'hdf;
  localparam logic [7:0] BCD_LIMIT = 8'h09;
  localparam logic [7:0] BCD_LO_FIX = 8'h06;
  localparam logic [7:0] BCD_HI_FIX = 8'h60;
  localparam int BANK_SHIFT = 3;
  ////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADDC = 5'h02, OP_SUBB = 5'h03,
    OP_MUL = 5'h04, OP_DIV = 5'h05, OP_DA = 5'h06, OP_CLRC = 5'h07,
    OP_SETC = 5'h08, OP_CPLC = 5'h09, OP_ANLC = 5'h0a, OP_ANLCN = 5'h0b,
    OP_ORLC = 5'h0c, OP_ORLCN = 5'h0d, OP_MOVC = 5'h0e, OP_RLC = 5'h0f,
    OP_RRC = 5'h10, OP_CJNE = 5'h11, OP_PUSH = 5'h12, OP_POP = 5'h13,
    OP_INCDP = 5'h14
  } ccs_op_type;

  typedef struct packed {
    logic valid;
    ccs_op_type op;
    logic [7:0] operand;
    logic bit_in;
  } ccs_cmd_type;

  typedef struct packed {
    logic acc_we;
    logic [7:0] acc;
    logic b_we;
    logic [7:0] b;
    logic cy_we;
    logic cy;
    logic ac_we;
    logic ac;
    logic ov_we;
    logic ov;
  } ccs_alu_res_type;
endpackage

/* ccs_alu.sv */
/*
  Combinational arithmetic and flag unit. Assumes its caller registers
  the results and applies only the fields whose write enable is set.
*/
`timescale 1ns/1ns
module ccs_alu (
  // operation and state
  input wire ccs_pkg::ccs_op_type i_op,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_b,
  input wire logic [7:0] i_operand,
  input wire logic i_bit,
  input wire logic i_cy,
  input wire logic i_ac,
  // results
  output ccs_pkg::ccs_alu_res_type o_res
);
  logic cin;
  logic [8:0] sum9;
  logic [4:0] sum_lo;
  logic [7:0] sum_b6;
  logic [8:0] sub_rhs;
  logic [4:0] sub_lo_rhs;
  logic [7:0] sub_b6_rhs;
  logic [15:0] prod;
  logic [8:0] da1;
  logic [8:0] da2;

  always_comb begin
    cin = (i_op == ccs_pkg::OP_ADD) ? 1'b0 : i_cy;
    sum9 = {1'b0, i_acc} + {1'b0, i_operand} + {8'h00, cin};
    sum_lo = {1'b0, i_acc[3:0]} + {1'b0, i_operand[3:0]} + {4'h0, cin};
    sum_b6 = {1'b0, i_acc[6:0]} + {1'b0, i_operand[6:0]} + {7'h00, cin};
    sub_rhs = {1'b0, i_operand} + {8'h00, i_cy};
    sub_lo_rhs = {1'b0, i_operand[3:0]} + {4'h0, i_cy};
    sub_b6_rhs = {1'b0, i_operand[6:0]} + {7'h00, i_cy};
    prod = i_acc * i_b;
    da1 = {1'b0, i_acc};
    if (i_acc[3:0] > ccs_pkg::BCD_LIMIT[3:0] || i_ac) begin
      da1 = {1'b0, i_acc} + {1'b0, ccs_pkg::BCD_LO_FIX};
    end
    da2 = da1;
    if (da1[7:4] > ccs_pkg::BCD_LIMIT[3:0] || i_cy || da1[8]) begin
      da2 = da1 + {1'b0, ccs_pkg::BCD_HI_FIX};
    end
    o_res = '0;
    o_res.acc = i_acc;
    o_res.b = i_b;
    o_res.cy = i_cy;
    unique case (i_op)
      ccs_pkg::OP_ADD, ccs_pkg::OP_ADDC: begin
        o_res = '{1'b1, sum9[7:0], 1'b0, i_b, 1'b1, sum9[8],
                  1'b1, sum_lo[4],
                  1'b1, sum9[8] ^ sum_b6[7]};
      end
      ccs_pkg::OP_SUBB: begin
        o_res.acc_we = 1'b1;
        o_res.acc = 8'(({1'b0, i_acc} - sub_rhs));
        o_res.cy_we = 1'b1;
        o_res.cy = ({1'b0, i_acc} < sub_rhs);
        o_res.ac_we = 1'b1;
        o_res.ac = ({1'b0, i_acc[3:0]} < sub_lo_rhs);
        o_res.ov_we = 1'b1;
        o_res.ov = ({1'b0, i_acc} < sub_rhs) ^ ({1'b0, i_acc[6:0]} < sub_b6_rhs);
      end
      ccs_pkg::OP_MUL: begin
        o_res = '{1'b1, prod[7:0], 1'b1, prod[15:8],
                  1'b1, 1'b0,
                  1'b0, 1'b0, 1'b1, (prod[15:8] != 8'h00)};
      end
      ccs_pkg::OP_DIV: begin
        o_res.cy_we = 1'b1;
        o_res.cy = 1'b0;
        o_res.ov_we = 1'b1;
        o_res.ov = (i_b == 8'h00);
        if (i_b != 8'h00) begin
          // results left unchanged on a zero divisor
          o_res.acc_we = 1'b1;
          o_res.acc = i_acc / i_b;
          o_res.b_we = 1'b1;
          o_res.b = i_acc % i_b;
        end
      end
      ccs_pkg::OP_DA: begin
        o_res.acc_we = 1'b1;
        o_res.acc = da2[7:0];
        o_res.cy_we = 1'b1;
        o_res.cy = da2[8] | i_cy;
      end
      ccs_pkg::OP_CLRC: begin
        o_res.cy_we = 1'b1;
        o_res.cy = 1'b0;
      end
      ccs_pkg::OP_SETC: o_res = '{1'b0, i_acc, 1'b0, i_b, 1'b1, 1'b1,
                                  1'b0, 1'b0, 1'b0, 1'b0};
      ccs_pkg::OP_CPLC, ccs_pkg::OP_ANLC, ccs_pkg::OP_ANLCN,
      ccs_pkg::OP_ORLC, ccs_pkg::OP_ORLCN, ccs_pkg::OP_MOVC: begin
        o_res.cy_we = 1'b1;
        unique case (i_op)
          ccs_pkg::OP_CPLC: o_res.cy = ~i_cy;
          ccs_pkg::OP_ANLC: o_res.cy = i_cy & i_bit;
          ccs_pkg::OP_ANLCN: o_res.cy = i_cy & ~i_bit;
          ccs_pkg::OP_ORLC: o_res.cy = i_cy | i_bit;
          ccs_pkg::OP_ORLCN: o_res.cy = i_cy | ~i_bit;
          default: o_res.cy = i_bit;
        endcase
      end
      ccs_pkg::OP_RLC: o_res = '{1'b1, {i_acc[6:0], i_cy}, 1'b0, i_b,
                                 1'b1, i_acc[7], 1'b0, 1'b0, 1'b0, 1'b0};
      ccs_pkg::OP_RRC: o_res = '{1'b1, {i_cy, i_acc[7:1]}, 1'b0, i_b,
                                 1'b1, i_acc[0], 1'b0, 1'b0, 1'b0, 1'b0};
      ccs_pkg::OP_CJNE: begin
        o_res.cy_we = 1'b1;
        o_res.cy = (i_acc < i_operand);
      end
      default: o_res.cy = i_cy;
    endcase
  end
endmodule

/* ccs_avs_slave.sv */
/*
  Avalon-MM handshake: one wait state per access, registered read data.
  Assumes the master holds its request until it sees waitrequest low.
*/
`timescale 1ns/1ns
module ccs_avs_slave (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // bus request
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [7:0] i_rd_value,
  // bus answer
  output logic o_waitrequest,
  output logic [31:0] o_readdata,
  output logic o_commit
);
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    // drop waitrequest for exactly one cycle per request
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    if ((i_read || i_write) && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = i_read ? {24'h000000, i_rd_value} : 32'h00000000;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_waitrequest = wait_reg;
  assign o_readdata = rdata_reg;
  assign o_commit = i_write && !wait_reg;
endmodule

/* ccs_core.sv */
/*
  Accumulator, auxiliary register, stack pointer, dual data pointer and
  status word of the processor core, with a command port for the
  instruction sequencer and an Avalon-MM register slave.
  Assumes one command per cycle on the same clock and a bus master
  that holds each request until waitrequest is low.
*/
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
module ccs_core (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register bus
  input wire logic [ccs_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // instruction command
  input wire ccs_pkg::ccs_cmd_type i_cmd,
  // stack access
  output logic o_stack_we,
  output logic o_stack_re,
  output logic [7:0] o_stack_addr,
  output logic [7:0] o_stack_data,
  // state seen by the rest of the core
  output logic [15:0] o_data_ptr,
  output logic [4:0] o_bank_base,
  output logic [7:0] o_acc,
  output logic [7:0] o_status
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] sp_reg;
  logic [7:0] sp_next;
  logic [15:0] data_ptr_word_reg;
  logic [15:0] data_ptr_word_next;
  logic [15:0] data_ptr_word_alt_reg;
  logic [15:0] data_ptr_word_alt_next;
  logic [7:0] aux1_reg;
  logic [7:0] aux1_next;
  logic [7:0] power_reg;
  logic [7:0] power_next;
  logic [7:0] psw_reg;
  logic [7:0] psw_next;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [7:0] b_reg;
  logic [7:0] b_next;
  logic stack_we_reg;
  logic stack_we_next;
  logic stack_re_reg;
  logic stack_re_next;
  logic [7:0] stack_addr_reg;
  logic [7:0] stack_addr_next;
  logic [7:0] stack_data_reg;
  logic [7:0] stack_data_next;
  logic [15:0] ptr_out_reg;
  logic [15:0] ptr_out_next;
  logic [4:0] bank_reg;
  logic [4:0] bank_next;

  logic [7:0] idx;
  logic mapped;
  logic [7:0] rd_value;
  logic commit;
  logic [7:0] wdata;
  logic wr_en;
  logic [15:0] act_ptr;
  ccs_pkg::ccs_alu_res_type alu_res;
  ccs_pkg::ccs_op_type cmd_op;

  ////////////////////////////////////////////////////////////////////
  // bus decode and read mux
  always_comb begin
    idx = i_avs_address[ccs_pkg::ADDR_W-1:2];
    mapped = (idx == ccs_pkg::IDX_STACK) || (idx == ccs_pkg::IDX_DPL) ||
             (idx == ccs_pkg::IDX_DPH) || (idx == ccs_pkg::IDX_POWER) ||
             (idx == ccs_pkg::IDX_AUX1) || (idx == ccs_pkg::IDX_STATUS) ||
             (idx == ccs_pkg::IDX_ACC) || (idx == ccs_pkg::IDX_AUXB);
    act_ptr = aux1_reg[ccs_pkg::AUX1_SEL] ? data_ptr_word_alt_reg : data_ptr_word_reg;
    unique case (idx)
      ccs_pkg::IDX_STACK: rd_value = sp_reg;
      ccs_pkg::IDX_DPL: rd_value = act_ptr[7:0];
      ccs_pkg::IDX_DPH: rd_value = act_ptr[15:8];
      ccs_pkg::IDX_POWER: rd_value = power_reg & ccs_pkg::POWER_RSV_MASK;
      ccs_pkg::IDX_AUX1: rd_value = aux1_reg;
      // parity is read live from the accumulator
      ccs_pkg::IDX_STATUS: rd_value = {psw_reg[7:1], ^acc_reg};
      ccs_pkg::IDX_ACC: rd_value = acc_reg;
      ccs_pkg::IDX_AUXB: rd_value = b_reg;
      default: rd_value = 8'h00;
    endcase
  end

  ccs_avs_slave u_slave (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_read(i_avs_read),
    .i_write(i_avs_write),
    .i_rd_value(rd_value),
    .o_waitrequest(o_avs_waitrequest),
    .o_readdata(o_avs_readdata),
    .o_commit(commit)
  );

  assign wdata = i_avs_writedata[7:0];
  assign wr_en = commit && mapped && i_avs_byteenable[0];
  assign cmd_op = i_cmd.valid ? i_cmd.op : ccs_pkg::OP_NOP;

  ccs_alu u_alu (
    .i_op(cmd_op),
    .i_acc(acc_reg),
    .i_b(b_reg),
    .i_operand(i_cmd.operand),
    .i_bit(i_cmd.bit_in),
    .i_cy(psw_reg[ccs_pkg::SW_CY]),
    .i_ac(psw_reg[ccs_pkg::SW_AC]),
    .o_res(alu_res)
  );

  ////////////////////////////////////////////////////////////////////
  // next state: bus writes first, an instruction overrides what it touches
  always_comb begin
    sp_next = sp_reg;
    data_ptr_word_next = data_ptr_word_reg;
    data_ptr_word_alt_next = data_ptr_word_alt_reg;
    aux1_next = aux1_reg;
    power_next = power_reg;
    psw_next = psw_reg;
    acc_next = acc_reg;
    b_next = b_reg;
    stack_we_next = 1'b0;
    stack_re_next = 1'b0;
    stack_addr_next = stack_addr_reg;
    stack_data_next = stack_data_reg;
    if (wr_en) begin
      unique case (idx)
        ccs_pkg::IDX_STACK: sp_next = wdata;
        ccs_pkg::IDX_DPL: begin
          if (aux1_reg[ccs_pkg::AUX1_SEL]) begin
            data_ptr_word_alt_next[7:0] = wdata;
          end else begin
            data_ptr_word_next[7:0] = wdata;
          end
        end
        ccs_pkg::IDX_DPH: begin
          if (aux1_reg[ccs_pkg::AUX1_SEL]) begin
            data_ptr_word_alt_next[15:8] = wdata;
          end else begin
            data_ptr_word_next[15:8] = wdata;
          end
        end
        // general flags are plain storage
        ccs_pkg::IDX_POWER: power_next = wdata & ccs_pkg::POWER_RSV_MASK;
        ccs_pkg::IDX_AUX1: aux1_next = wdata;
        // parity bit ignores writes
        ccs_pkg::IDX_STATUS: psw_next = {wdata[7:1], psw_reg[ccs_pkg::SW_P]};
        ccs_pkg::IDX_ACC: acc_next = wdata;
        ccs_pkg::IDX_AUXB: b_next = wdata;
        default: sp_next = sp_reg;
      endcase
    end
    if (alu_res.acc_we) begin
      acc_next = alu_res.acc;
    end
    if (alu_res.b_we) begin
      b_next = alu_res.b;
    end
    if (alu_res.cy_we) begin
      psw_next[ccs_pkg::SW_CY] = alu_res.cy;
    end
    if (alu_res.ac_we) begin
      psw_next[ccs_pkg::SW_AC] = alu_res.ac;
    end
    if (alu_res.ov_we) begin
      psw_next[ccs_pkg::SW_OV] = alu_res.ov;
    end
    unique case (cmd_op)
      ccs_pkg::OP_PUSH: begin
        // pointer moves up before the byte is stored
        sp_next = sp_reg + 8'h01;
        stack_we_next = 1'b1;
        stack_addr_next = sp_reg + 8'h01;
        stack_data_next = i_cmd.operand;
      end
      ccs_pkg::OP_POP: begin
        sp_next = sp_reg - 8'h01;
        stack_re_next = 1'b1;
        stack_addr_next = sp_reg;
      end
      ccs_pkg::OP_INCDP: begin
        if (aux1_reg[ccs_pkg::AUX1_SEL]) begin
          data_ptr_word_alt_next = data_ptr_word_alt_reg + 16'h0001;
        end else begin
          data_ptr_word_next = data_ptr_word_reg + 16'h0001;
        end
      end
      default: stack_data_next = stack_data_reg;
    endcase
    psw_next[ccs_pkg::SW_P] = ^acc_next;
    ptr_out_next = aux1_next[ccs_pkg::AUX1_SEL] ? data_ptr_word_alt_next : data_ptr_word_next;
    bank_next = 5'({psw_next[ccs_pkg::SW_RS1], psw_next[ccs_pkg::SW_RS0]})
                << ccs_pkg::BANK_SHIFT;
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sp_reg <= ccs_pkg::RST_STACK;
      data_ptr_word_reg <= 16'h0000;
      data_ptr_word_alt_reg <= 16'h0000;
      aux1_reg <= ccs_pkg::RST_ZERO;
      power_reg <= ccs_pkg::RST_POWER;
      psw_reg <= ccs_pkg::RST_ZERO;
      acc_reg <= ccs_pkg::RST_ZERO;
      b_reg <= ccs_pkg::RST_ZERO;
      stack_we_reg <= 1'b0;
      stack_re_reg <= 1'b0;
      stack_addr_reg <= 8'h00;
      stack_data_reg <= 8'h00;
      ptr_out_reg <= 16'h0000;
      bank_reg <= 5'h00;
    end else begin
      sp_reg <= sp_next;
      data_ptr_word_reg <= data_ptr_word_next;
      data_ptr_word_alt_reg <= data_ptr_word_alt_next;
      aux1_reg <= aux1_next;
      power_reg <= power_next;
      psw_reg <= psw_next;
      acc_reg <= acc_next;
      b_reg <= b_next;
      stack_we_reg <= stack_we_next;
      stack_re_reg <= stack_re_next;
      stack_addr_reg <= stack_addr_next;
      stack_data_reg <= stack_data_next;
      ptr_out_reg <= ptr_out_next;
      bank_reg <= bank_next;
    end
  end

  assign o_stack_we = stack_we_reg;
  assign o_stack_re = stack_re_reg;
  assign o_stack_addr = stack_addr_reg;
  assign o_stack_data = stack_data_reg;
  assign o_data_ptr = ptr_out_reg;
  assign o_bank_base = bank_reg;
  assign o_acc = acc_reg;
  assign o_status = psw_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  a_push_pre_inc: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cmd_op == ccs_pkg::OP_PUSH && !wr_en |=> o_stack_we &&
    o_stack_addr == $past(sp_reg) + 8'h01 && sp_reg == o_stack_addr)
    else $error("push did not pre-increment the stack pointer");

  a_ptr_select: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_data_ptr == (aux1_reg[ccs_pkg::AUX1_SEL] ? data_ptr_word_alt_reg : data_ptr_word_reg))
    else $error("active pointer output does not follow the selector");

  a_muldiv_carry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cmd_op inside {ccs_pkg::OP_MUL, ccs_pkg::OP_DIV} |=> !psw_reg[ccs_pkg::SW_CY])
    else $error("carry not cleared after multiply or divide");

  a_add_carry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cmd_op == ccs_pkg::OP_ADD |=> {psw_reg[ccs_pkg::SW_CY], acc_reg} ==
    {1'b0, $past(acc_reg)} + {1'b0, $past(i_cmd.operand)})
    else $error("add result or carry wrong");

  a_cmp_carry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cmd_op == ccs_pkg::OP_CJNE |=>
    psw_reg[ccs_pkg::SW_CY] == ($past(acc_reg) < $past(i_cmd.operand)))
    else $error("compare carry wrong");

  a_mul_split: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cmd_op == ccs_pkg::OP_MUL |=> {b_reg, acc_reg} == $past(acc_reg) * $past(b_reg)
    && psw_reg[ccs_pkg::SW_OV] == (b_reg != 8'h00))
    else $error("multiply result or overflow wrong");

  a_div_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cmd_op == ccs_pkg::OP_DIV |=>
    psw_reg[ccs_pkg::SW_OV] == ($past(b_reg) == 8'h00))
    else $error("divide overflow flag wrong");

  a_parity_live: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    psw_reg[ccs_pkg::SW_P] == ^acc_reg)
    else $error("parity bit disagrees with accumulator");

  a_bank_base: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_bank_base == {psw_reg[ccs_pkg::SW_RS1], psw_reg[ccs_pkg::SW_RS0], 3'b000})
    else $error("bank base not eight times bank select");

  a_set_carry: assert property (
    cmd_op == ccs_pkg::OP_SETC |=> psw_reg[ccs_pkg::SW_CY])
    else $error("set carry wrong");

  a_clr_carry: assert property (
    cmd_op == ccs_pkg::OP_CLRC |=> !psw_reg[ccs_pkg::SW_CY])
    else $error("clear carry wrong");

  a_sub_borrow: assert property (
    cmd_op == ccs_pkg::OP_SUBB |=> {psw_reg[ccs_pkg::SW_CY], acc_reg} ==
    {1'b0, $past(acc_reg)} - {1'b0, $past(i_cmd.operand)} - $past(psw_reg[ccs_pkg::SW_CY]))
    else $error("subtract result or borrow wrong");

  a_half_carry: assert property (
    cmd_op == ccs_pkg::OP_ADD |=> psw_reg[ccs_pkg::SW_AC] ==
    ({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(i_cmd.operand[3:0])} > 5'h0f))
    else $error("half carry wrong");

  a_add_signed: assert property (
    cmd_op == ccs_pkg::OP_ADD |=> psw_reg[ccs_pkg::SW_OV] == ($past(acc_reg[7]) ==
    $past(i_cmd.operand[7]) && acc_reg[7] != $past(acc_reg[7])))
    else $error("add overflow wrong");

  a_div_split: assert property (
    cmd_op == ccs_pkg::OP_DIV && b_reg != 8'h00 |=> acc_reg == $past(acc_reg) / $past(b_reg)
    && b_reg == $past(acc_reg) % $past(b_reg))
    else $error("quotient or remainder wrong");

  a_pop_stack: assert property (
    cmd_op == ccs_pkg::OP_POP |=> o_stack_re && o_stack_addr == $past(sp_reg)
    && sp_reg == $past(sp_reg) - 8'h01)
    else $error("pop did not post-decrement");

  a_push_data: assert property (
    cmd_op == ccs_pkg::OP_PUSH |=> o_stack_data == $past(i_cmd.operand))
    else $error("pushed byte wrong");

  a_ptr_step: assert property (
    cmd_op == ccs_pkg::OP_INCDP && !wr_en |=> o_data_ptr == $past(act_ptr) + 16'h0001)
    else $error("pointer increment wrong");

  a_one_wait: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for two cycles");

  a_unmapped_zero: assert property (
    i_avs_read && o_avs_waitrequest && !mapped |=> o_avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

/* ccs_core_tb.sv */
/*
  Self-checking bench for ccs_core: register bus, flags, pointers, stack.
  Assumes ccs_pkg and the design files are compiled before it.
*/
`timescale 1ns/1ns
module ccs_core_tb;
  logic i_ref_clk;
  logic i_rst_n;
  logic [9:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic waitreq;
  ccs_pkg::ccs_cmd_type cmd;
  logic swe;
  logic sre;
  logic [7:0] saddr;
  logic [7:0] sdata;
  logic [15:0] data_ptr_word;
  logic [4:0] bbase;
  logic [7:0] acc;
  logic [7:0] st;
  logic [31:0] seed;
  logic [7:0] v;
  logic [7:0] a;
  logic [7:0] b;
  logic c;
  logic [15:0] p;
  int fail_count;
  int compares;
  logic [7:0] zidx [6] = '{ccs_pkg::IDX_DPL, ccs_pkg::IDX_DPH, ccs_pkg::IDX_STATUS,
    ccs_pkg::IDX_ACC, ccs_pkg::IDX_AUXB, 8'h55};

  ccs_core dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_cmd(cmd), .o_stack_we(swe),
    .o_stack_re(sre), .o_stack_addr(saddr), .o_stack_data(sdata), .o_data_ptr(data_ptr_word),
    .o_bank_base(bbase), .o_acc(acc), .o_status(st));

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // {cy, ac, ov, result} of add or subtract with borrow
  function automatic logic [10:0] f_arith(input logic [7:0] x, input logic [7:0] y,
                                          input logic ci, input logic sub);
    logic [8:0] r;
    logic h;
    logic c6;
    if (sub) begin
      r = {1'b0, x} - {1'b0, y} - ci;
      h = {1'b0, x[3:0]} < ({1'b0, y[3:0]} + ci);
      c6 = {1'b0, x[6:0]} < ({1'b0, y[6:0]} + ci);
    end else begin
      r = x + y + ci;
      h = (x[3:0] + y[3:0] + ci) > 5'h0f;
      c6 = (x[6:0] + y[6:0] + ci) > 8'h7f;
    end
    return {r[8], h, c6 ^ r[8], r[7:0]};
  endfunction

  // {cy, acc} after one carry, rotate, compare or decimal adjust command
  function automatic logic [8:0] f_bit(input int k, input logic cy, input logic bi,
                                       input logic [7:0] x, input logic [7:0] y);
    logic [8:0] t;
    case (k)
      6: begin
        t = {1'b0, x};
        if (t[3:0] > 4'h9) t = t + 9'h006;
        if (t[7:4] > 4'h9 || cy || t[8]) t = t + 9'h060;
        return {t[8] | cy, t[7:0]};
      end
      7: return {1'b0, x};
      8: return {1'b1, x};
      9: return {~cy, x};
      10: return {cy & bi, x};
      11: return {cy & ~bi, x};
      12: return {cy | bi, x};
      13: return {cy | ~bi, x};
      14: return {bi, x};
      15: return {x, cy};
      16: return {x[0], cy, x[7:1]};
      default: return {x < y, x};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge i_ref_clk);
    addr <= {idx, 2'b00};
    rd <= ~w;
    wr <= w;
    wdata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 16);
    v = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 16) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic op(input int k, input logic [7:0] x, input logic bi);
    @(posedge i_ref_clk);
    cmd <= '{1'b1, ccs_pkg::ccs_op_type'(k), x, bi};
    @(posedge i_ref_clk);
    cmd.valid <= 1'b0;
    @(negedge i_ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    compares = 0;
    seed = 32'hdb3d4822;
    i_rst_n = 1'b0;
    addr = 10'h000;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h00000000;
    be = 4'h1;
    cmd = '0;
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    bus(0, ccs_pkg::IDX_STACK, 0);
    chk("stack reset", 16'h0007, v);
    foreach (zidx[i]) begin
      bus(0, zidx[i], 0);
      chk("zero reset or unmapped", 16'h0000, v);
    end
    bus(0, ccs_pkg::IDX_POWER, 0);
    chk("power reset", 16'h0010, v);
    bus(1, ccs_pkg::IDX_POWER, 8'hff);
    bus(0, ccs_pkg::IDX_POWER, 0);
    chk("power flags", 16'h00df, v);
    for (int i = 0; i < 30; i++) begin
      a = (i == 0) ? 8'h7f : 8'(rnd());
      b = (i == 0) ? 8'h01 : 8'(rnd());
      c = 1'(rnd());
      bus(1, ccs_pkg::IDX_STATUS, {c, 7'h00});
      bus(1, ccs_pkg::IDX_ACC, a);
      op(1 + i % 3, b, 0);
      p = 16'(f_arith(a, b, c & (i % 3 != 0), i % 3 == 2));
      chk("arith", p, {st[7], st[6], st[2], acc});
      chk("parity", ^p[7:0], st[0]);
    end
    for (int i = 0; i < 12; i++) begin
      a = (i < 4) ? 8'hff : 8'(rnd());
      b = (i < 2) ? 8'h00 : (i < 4) ? 8'hff : 8'(rnd());
      p = a * b;
      bus(1, ccs_pkg::IDX_STATUS, 8'h80);
      bus(1, ccs_pkg::IDX_AUXB, b);
      bus(1, ccs_pkg::IDX_ACC, a);
      op(4 + i % 2, 8'h00, 0);
      bus(0, ccs_pkg::IDX_AUXB, 0);
      if (i % 2 == 0) begin
        chk("product", p, {v, acc});
        chk("mul flags", {1'b0, p > 16'h00ff}, {st[7], st[2]});
      end else if (b == 8'h00) begin
        chk("div zero", {a, b}, {acc, v});
        chk("div zero flags", 16'h0001, {st[7], st[2]});
      end else begin
        chk("quotient", {a % b, a / b}, {v, acc});
        chk("div flags", 16'h0000, {st[7], st[2]});
      end
    end
    for (int i = 0; i < 48; i++) begin
      a = 8'(rnd());
      b = 8'(rnd());
      c = 1'(rnd());
      bus(1, ccs_pkg::IDX_STATUS, {c, 7'h00});
      bus(1, ccs_pkg::IDX_ACC, a);
      op(6 + i % 12, b, b[3]);
      chk("carry op", f_bit(6 + i % 12, c, b[3], a, b), {st[7], acc});
    end
    for (int k = 0; k < 4; k++) begin
      bus(1, ccs_pkg::IDX_STATUS, k << 3 | 8'h22);
      @(negedge i_ref_clk);
      chk("bank base", k * 8, bbase);
      bus(0, ccs_pkg::IDX_STATUS, 0);
      chk("user flags", k << 3 | 8'h22 | ^acc, v);
    end
    op(18, 8'ha5, 0);
    chk("push", {swe, 3'h0, saddr, 3'h0, sre}, {1'b1, 3'h0, 8'h08, 3'h0, 1'b0});
    chk("push data", 16'h00a5, sdata);
    op(19, 8'h00, 0);
    chk("pop", 16'h0108, {sre, saddr});
    bus(0, ccs_pkg::IDX_STACK, 0);
    chk("pop pointer", 16'h0007, v);
    bus(1, ccs_pkg::IDX_DPL, 8'h34);
    bus(1, ccs_pkg::IDX_DPH, 8'h12);
    @(negedge i_ref_clk);
    chk("pointer", 16'h1234, data_ptr_word);
    bus(1, ccs_pkg::IDX_AUX1, 8'h01);
    @(negedge i_ref_clk);
    chk("alt pointer", 16'h0000, data_ptr_word);
    bus(1, ccs_pkg::IDX_DPL, 8'hff);
    op(20, 8'h00, 0);
    chk("alt increment", 16'h0100, data_ptr_word);
    bus(1, ccs_pkg::IDX_AUX1, 8'h00);
    be <= 4'h0;
    bus(1, ccs_pkg::IDX_DPL, 8'h99);
    be <= 4'h1;
    bus(0, ccs_pkg::IDX_DPL, 0);
    chk("main pointer", 16'h1234, data_ptr_word);
    chk("pointer byte", 16'h0034, v);
    stop_test();
  end
endmodule
